// ==== core/dsg_pkg.sv ====
`default_nettype none
package dsg_pkg;
  // Register map, byte addresses within the system control space
  localparam logic [11:0] DSG_OFF_DEEP_GATE = 12'h124;
  localparam logic [11:0] DSG_OFF_RUN_GATE = 12'h104;
  localparam logic [11:0] DSG_OFF_SLEEP_GATE = 12'h114;
  localparam logic [11:0] DSG_OFF_RUN_CFG = 12'h060;
  // Reset values
  localparam logic [31:0] DSG_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] DSG_CFG_RESET = 32'h0000_0000;
  // Writable gate bits: comparators 26:24, counters 19:16, 12, 8, serial 4, 2:0
  localparam logic [31:0] DSG_GATE_MASK = 32'h070f_1117;
  localparam int DSG_POS_COMPARATOR0_GATE = 24;
  localparam int DSG_POS_GPC0 = 16;
  localparam int DSG_POS_TWO_WIRE = 12;
  localparam int DSG_POS_ENCODER = 8;
  localparam int DSG_POS_SYNC_SERIAL = 4;
  localparam int DSG_POS_ASYNC0 = 0;
  // Automatic gating select bit in the run configuration register
  localparam int DSG_POS_AUTO_GATING = 27;
  localparam logic [31:0] DSG_CFG_MASK = 32'h0800_0000;
  // Power modes from the core
  typedef enum logic [2:0] {
    DSG_MODE_RUN = 3'b001,
    DSG_MODE_SLEEP = 3'b010,
    DSG_MODE_DEEP = 3'b100
  } dsg_mode_e;
endpackage : dsg_pkg
`default_nettype wire

// ==== core/dsg_gate_reg.sv ====
`default_nettype none
// One masked read-write gate register; bits outside the mask stay zero
module dsg_gate_reg
  import dsg_pkg::*;
#(
  parameter logic [31:0] MASK = DSG_GATE_MASK,
  parameter logic [31:0] RESET = DSG_GATE_RESET
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] byte_en,
  output logic [31:0] value
);
  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] lane_mask;

  // Byte lanes widen into a bit mask, then the reserved bits are cut away
  assign lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}} & MASK;
  assign value_next = wr_en ? ((value_reg & ~lane_mask) | (wr_data & lane_mask)) : value_reg;
  assign value = value_reg;

  // Register storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= RESET;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule : dsg_gate_reg
`default_nettype wire

// ==== core/dsg_clock_gate.sv ====
// Register access over Avalon-MM is this design's own decision.
`default_nettype none
module dsg_clock_gate
  import dsg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [2:0] power_mode,
  input wire logic [31:0] unit_access,
  output logic [31:0] unit_clk_en,
  output logic [31:0] unit_bus_fault,
  output logic auto_gating_select
);
  logic done_reg;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;
  logic [31:0] clk_en_reg;
  logic [31:0] fault_reg;
  logic [11:0] byte_addr;
  logic req;
  logic take;
  logic hit_run;
  logic hit_sleep;
  logic hit_deep;
  logic hit_cfg;
  logic hit_any;
  logic [31:0] run_gate;
  logic [31:0] sleep_gate;
  logic [31:0] deep_gate;
  logic [31:0] run_cfg;
  logic [31:0] rdata_next;
  logic [31:0] active_gate;
  logic [31:0] fault_next;

  // Word address decode; the bus addresses whole words
  assign byte_addr = {avs_address, 2'b00};
  assign req = (avs_read | avs_write) & ~done_reg;
  // Transfer is taken where waitrequest is low; writes land only at that edge, never during the stall
  assign take = (avs_read | avs_write) & ~avs_waitrequest;
  assign hit_deep = byte_addr == DSG_OFF_DEEP_GATE;
  assign hit_run = byte_addr == DSG_OFF_RUN_GATE;
  assign hit_sleep = byte_addr == DSG_OFF_SLEEP_GATE;
  assign hit_cfg = byte_addr == DSG_OFF_RUN_CFG;
  assign hit_any = hit_deep | hit_run | hit_sleep | hit_cfg;

  dsg_gate_reg #(.MASK(DSG_GATE_MASK), .RESET(DSG_GATE_RESET)) u_run (
    .clk(clk), .rst(rst), .wr_en(take & avs_write & hit_run),
    .wr_data(avs_writedata), .byte_en(avs_byteenable), .value(run_gate)
  );
  dsg_gate_reg #(.MASK(DSG_GATE_MASK), .RESET(DSG_GATE_RESET)) u_sleep (
    .clk(clk), .rst(rst), .wr_en(take & avs_write & hit_sleep),
    .wr_data(avs_writedata), .byte_en(avs_byteenable), .value(sleep_gate)
  );
  // Reserved bits masked off in the deep-sleep register
  dsg_gate_reg #(.MASK(DSG_GATE_MASK), .RESET(DSG_GATE_RESET)) u_deep (
    .clk(clk), .rst(rst), .wr_en(take & avs_write & hit_deep),
    .wr_data(avs_writedata), .byte_en(avs_byteenable), .value(deep_gate)
  );
  dsg_gate_reg #(.MASK(DSG_CFG_MASK), .RESET(DSG_CFG_RESET)) u_cfg (
    .clk(clk), .rst(rst), .wr_en(take & avs_write & hit_cfg),
    .wr_data(avs_writedata), .byte_en(avs_byteenable), .value(run_cfg)
  );
  assign auto_gating_select = run_cfg[DSG_POS_AUTO_GATING];

  // Read mux; unmapped words read zero
  assign rdata_next = hit_deep ? deep_gate : hit_run ? run_gate : hit_sleep ? sleep_gate : hit_cfg ? run_cfg : 32'h0;

  // Mode selection; the run register governs unless automatic gating is on in sleep or deep-sleep mode
  assign active_gate = !auto_gating_select ? run_gate :
                       (power_mode == DSG_MODE_DEEP) ? deep_gate :
                       (power_mode == DSG_MODE_SLEEP) ? sleep_gate : run_gate;
  // Access to an unclocked unit faults
  assign fault_next = unit_access & ~active_gate;

  // Bus answer one cycle after the request; waitrequest drops on that cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~done_reg;
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;
  assign unit_clk_en = clk_en_reg;
  assign unit_bus_fault = fault_reg;

  // Bus slave state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
      rdata_reg <= 32'h0;
      resp_reg <= 2'b00;
    end else begin
      done_reg <= req;
      rdata_reg <= (req & avs_read) ? rdata_next : rdata_reg;
      resp_reg <= req ? (hit_any ? 2'b00 : 2'b11) : resp_reg;
    end
  end

  // Registered enables keep glitches off the gated clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_en_reg <= DSG_GATE_RESET;
      fault_reg <= 32'h0;
    end else begin
      clk_en_reg <= active_gate;
      fault_reg <= fault_next;
    end
  end

  property p_reset_zero;
    @(posedge clk) $fell(rst) |-> (deep_gate == DSG_GATE_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("deep gate not zero after reset");

  property p_reserved;
    @(posedge clk) disable iff (rst) (deep_gate & ~DSG_GATE_MASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_fault;
    @(posedge clk) disable iff (rst) (unit_access & ~active_gate) != 32'h0 |=> unit_bus_fault != 32'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("missing bus fault");

  property p_no_fault;
    @(posedge clk) disable iff (rst) (unit_access & ~active_gate) == 32'h0 |=> unit_bus_fault == 32'h0;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("spurious bus fault");

  property p_deep_use;
    @(posedge clk) disable iff (rst) (auto_gating_select && power_mode == DSG_MODE_DEEP)
      |=> unit_clk_en == $past(deep_gate);
  endproperty
  a_deep_use: assert property (p_deep_use) else $error("deep gate not applied");

  property p_run_use;
    @(posedge clk) disable iff (rst) !auto_gating_select |=> unit_clk_en == $past(run_gate);
  endproperty
  a_run_use: assert property (p_run_use) else $error("run gate not applied");

  property p_sleep_use;
    @(posedge clk) disable iff (rst) (auto_gating_select && power_mode == DSG_MODE_SLEEP)
      |=> unit_clk_en == $past(sleep_gate);
  endproperty
  a_sleep_use: assert property (p_sleep_use) else $error("sleep gate not applied");

  property p_write;
    @(posedge clk) disable iff (rst) (take && avs_write && hit_deep && avs_byteenable == 4'hf)
      |=> deep_gate == ($past(avs_writedata) & DSG_GATE_MASK);
  endproperty
  a_write: assert property (p_write) else $error("deep gate write lost");

  property p_comp_bits;
    @(posedge clk) disable iff (rst) (take && avs_write && hit_deep && avs_byteenable[3])
      |=> deep_gate[26:24] == $past(avs_writedata[26:24]);
  endproperty
  a_comp_bits: assert property (p_comp_bits) else $error("comparator bits wrong");

  property p_serial_bits;
    @(posedge clk) disable iff (rst) (take && avs_write && hit_deep && avs_byteenable[0])
      |=> deep_gate[2:0] == $past(avs_writedata[2:0]) && deep_gate[4] == $past(avs_writedata[4]);
  endproperty
  a_serial_bits: assert property (p_serial_bits) else $error("serial bits wrong");

  property p_counter_bits;
    @(posedge clk) disable iff (rst) (take && avs_write && hit_deep && avs_byteenable[2] && avs_byteenable[1])
      |=> deep_gate[19:16] == $past(avs_writedata[19:16]) && deep_gate[12] == $past(avs_writedata[12])
      && deep_gate[8] == $past(avs_writedata[8]);
  endproperty
  a_counter_bits: assert property (p_counter_bits) else $error("counter bits wrong");

  property p_wait;
    @(posedge clk) disable iff (rst) (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held too long");

  // Fault pattern matches the gated accesses bit for bit
  property p_fault_exact;
    @(posedge clk) disable iff (rst) (unit_access != 32'h0) |=> unit_bus_fault == $past(fault_next);
  endproperty
  a_fault_exact: assert property (p_fault_exact) else $error("bus fault pattern wrong");

  // A stalled request must not touch the deep register
  property p_stall_hold;
    @(posedge clk) disable iff (rst) avs_waitrequest |=> $stable(deep_gate);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("deep gate changed during a stall");

  // Deep register contents stand on the read data in the answer cycle
  property p_read_deep;
    @(posedge clk) disable iff (rst) (req && avs_read && hit_deep) |=> avs_readdata == $past(deep_gate);
  endproperty
  a_read_deep: assert property (p_read_deep) else $error("deep gate read data wrong");

  // Unmapped words answer with a decode error
  property p_decode_err;
    @(posedge clk) disable iff (rst) (req && !hit_any) |=> avs_response == 2'b11;
  endproperty
  a_decode_err: assert property (p_decode_err) else $error("unmapped word not refused");

  // Units leave reset unclocked and without faults
  property p_reset_units;
    @(posedge clk) $fell(rst) |-> (unit_clk_en == 32'h0) && (unit_bus_fault == 32'h0);
  endproperty
  a_reset_units: assert property (p_reset_units) else $error("units not idle after reset");
endmodule : dsg_clock_gate
`default_nettype wire

// ==== tb/test_deep_sleep_clock_gating_reg1.sv ====
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module test_deep_sleep_clock_gating_reg1
  import dsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, auto_gating_select;
  logic [9:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, unit_access = '0, unit_clk_en, unit_bus_fault;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic [2:0] power_mode = DSG_MODE_RUN;
  int miscompares = 0, checked = 0, seed = 32'h26f9;
  logic [31:0] shadow [4];
  logic [9:0] addr_tab [4] = '{DSG_OFF_RUN_GATE[11:2], DSG_OFF_SLEEP_GATE[11:2], DSG_OFF_DEEP_GATE[11:2],
    DSG_OFF_RUN_CFG[11:2]};
  logic [31:0] mask_tab [4] = '{DSG_GATE_MASK, DSG_GATE_MASK, DSG_GATE_MASK, DSG_CFG_MASK};
  logic [2:0] mode_tab [4] = '{DSG_MODE_RUN, DSG_MODE_SLEEP, DSG_MODE_DEEP, 3'b011};
  logic [31:0] q, d, acc;
  logic [1:0] r;
  logic [3:0] be;
  dsg_clock_gate DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .power_mode(power_mode), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
    .unit_bus_fault(unit_bus_fault), .auto_gating_select(auto_gating_select));
  // Free-running system clock, 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Verdict in one place; the run always ends here
  task automatic close_out();
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // Lane merge of a partial write, then masked to the writable bits
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] lanes, logic [31:0] m);
    logic [31:0] lm;
    lm = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    return ((old & ~lm) | (wd & lm)) & m;
  endfunction : merge
  // Gate register that should steer the unit clocks
  function automatic logic [31:0] active(logic [2:0] m);
    if (!shadow[3][DSG_POS_AUTO_GATING]) return shadow[0];
    case (m)
      DSG_MODE_SLEEP: return shadow[1];
      DSG_MODE_DEEP: return shadow[2];
      default: return shadow[0];
    endcase
  endfunction : active
  // One bus transfer; request held until waitrequest is sampled low at a rising edge, released there
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd, input logic [3:0] lanes);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    avs_byteenable <= lanes;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("MISMATCH t=%0t bus wait timed out", $time);
      close_out();
    end
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Check clock enables and faults for every power mode against the model
  task automatic check_modes();
    for (int k = 0; k < 4; k++) begin
      acc = $random(seed);
      @(posedge clk);
      power_mode <= mode_tab[k];
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(unit_clk_en, active(mode_tab[k]), "clock enables")
      @(posedge clk);
      unit_access <= acc;
      @(posedge clk);
      unit_access <= '0;
      @(negedge clk);
      `CHK(unit_bus_fault, acc & ~active(mode_tab[k]), "bus fault")
    end
  endtask : check_modes
  initial begin
    shadow = '{default: '0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, addr_tab[i], '0, 4'hf);
      `CHK(q, 32'h0000_0000, "reset value")
    end
    check_modes();
    // Software turns on the units it needs
    // Random writes with random lanes, corners first: all ones, then no lanes
    for (int i = 0; i < 40; i++) begin
      d = (i < 4) ? 32'hffff_ffff : $random(seed);
      be = (i < 4) ? 4'hf : (i < 8 ? 4'h0 : 4'($random(seed)));
      bus(1'b1, addr_tab[i % 4], d, be);
      shadow[i % 4] = merge(shadow[i % 4], d, be, mask_tab[i % 4]);
      bus(1'b0, addr_tab[i % 4], '0, 4'hf);
      `CHK(q, shadow[i % 4], "readback")
      `CHK(r, 2'b00, "response ok")
      `CHK(auto_gating_select, shadow[3][DSG_POS_AUTO_GATING], "auto select")
      if (i % 4 == 3) check_modes();
    end
    // Unmapped word: write ignored, read zero with decode error
    bus(1'b1, 10'h3ff, 32'hffff_ffff, 4'hf);
    bus(1'b0, 10'h3ff, '0, 4'hf);
    `CHK(q, 32'h0000_0000, "unmapped data")
    `CHK(r, 2'b11, "unmapped response")
    bus(1'b0, addr_tab[2], '0, 4'hf);
    // deep register untouched by stray write
    `CHK(q, shadow[2], "deep after unmapped")
    // Read-modify-write that keeps the reserved bits as read
    bus(1'b0, addr_tab[2], '0, 4'hf);
    d = (q & ~DSG_GATE_MASK) | ($random(seed) & DSG_GATE_MASK);
    bus(1'b1, addr_tab[2], d, 4'hf);
    shadow[2] = merge(shadow[2], d, 4'hf, DSG_GATE_MASK);
    bus(1'b0, addr_tab[2], '0, 4'hf);
    `CHK(q, shadow[2], "read-modify-write")
    `CHK(q & ~DSG_GATE_MASK, 32'h0000_0000, "reserved bits zero")
    // Second reset in mid-run clears everything again
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    shadow = '{default: '0};
    bus(1'b0, addr_tab[2], '0, 4'hf);
    `CHK(q, 32'h0000_0000, "deep after reset")
    check_modes();
    close_out();
  end
endmodule : test_deep_sleep_clock_gating_reg1
`undef CHK
`default_nettype wire
